// ---- ccu_pkg.sv ----
package ccu_pkg;

    // register word offsets on the plain register port
    localparam int CCU_AW = 8;
    localparam logic [7:0] CCU_OFS_CTRL = 8'h00;
    localparam logic [7:0] CCU_OFS_STIME = 8'h04;
    localparam logic [7:0] CCU_OFS_STATUS = 8'h08;
    localparam logic [7:0] CCU_OFS_CAP0 = 8'h0C;
    localparam logic [7:0] CCU_OFS_CAP1 = 8'h10;
    localparam logic [7:0] CCU_OFS_DIFF = 8'h14;
    localparam logic [7:0] CCU_OFS_COUNT = 8'h18;

    // control fields, bit 0 first: en_req, cont, samp_sel, cont_err,
    // samp_src[5:4], c0_src 6, c0_edge[8:7], c1_src 9, c1_edge[11:10]
    localparam int CCU_CTRL_W = 12;
    localparam int CCU_STIME_W = 16;
    localparam int CCU_STATUS_ERR_BIT = 2;

    // reset values
    localparam logic [11:0] CCU_CTRL_RST = 12'h000;
    localparam logic [15:0] CCU_STIME_RST = 16'h0001;

    // edge qualifiers of a plain capture trigger
    localparam logic [1:0] CCU_EDGE_RISE = 2'h1;
    localparam logic [1:0] CCU_EDGE_FALL = 2'h2;
    localparam logic [1:0] CCU_EDGE_BOTH = 2'h3;

    // start sources of sampling capture
    typedef enum logic [1:0] {
        CCU_SS_C0_HIGH = 2'h0,
        CCU_SS_C0_LOW = 2'h1,
        CCU_SS_ENREQ = 2'h2
    } ccu_ssrc_t;

    typedef struct packed {
        logic [1:0] c1_edge;
        logic c1_src;
        logic [1:0] c0_edge;
        logic c0_src;
        ccu_ssrc_t samp_src;
        logic cont_err;
        logic samp_sel;
        logic cont;
        logic en_req;
    } ccu_ctrl_t;

    // status word: bit0 capture 0, bit1 capture 1, bit2 error, bit3 running
    typedef struct packed {
        logic run;
        logic err;
        logic cap1;
        logic cap0;
    } ccu_status_t;

endpackage

// ---- ccu_edge.sv ----
`timescale 1ns/1ps

// previous-level register of a few synchronous levels; edges are
// combinational so a capture lands in the cycle the edge is seen
module ccu_edge #(
    parameter int W = 4
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [W-1:0] level_in,
    output logic [W-1:0] rise_out,
    output logic [W-1:0] fall_out
);
    logic [W-1:0] prev_r;
    logic [W-1:0] prev_nxt;

    // next previous level is simply the present level
    always_comb begin
        prev_nxt = level_in;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_r <= '0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    // history resets low, so a level already high at release reads as a rising edge;
    // the enable resets off, so such an edge cannot start a plain capture
    assign rise_out = level_in & ~prev_r;
    assign fall_out = ~level_in & prev_r;

endmodule // ccu_edge

// ---- ccu_timer.sv ----
`timescale 1ns/1ps

// sampling time down-counter; a load while busy restarts the interval
module ccu_timer
    import ccu_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic load_in,
    input wire logic abort_in,
    input wire logic [CCU_STIME_W-1:0] value_in,
    output logic expire_out
);
    logic [CCU_STIME_W-1:0] cnt_r;
    logic [CCU_STIME_W-1:0] cnt_nxt;
    logic busy_r;
    logic busy_nxt;

    // a zero time is treated as one cycle so the interval always ends
    always_comb begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        if (abort_in) begin
            busy_nxt = 1'b0;
        end else if (load_in) begin
            cnt_nxt = (value_in == '0) ? CCU_STIME_W'(1) : value_in;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            cnt_nxt = cnt_r - CCU_STIME_W'(1);
            busy_nxt = (cnt_r != CCU_STIME_W'(1));
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    // expiry is the last busy cycle, unless a restart or an abort replaces it
    assign expire_out = busy_r && (cnt_r == CCU_STIME_W'(1)) && !load_in && !abort_in;

endmodule // ccu_timer

// ---- ccu_capture.sv ----
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - continuous plain capture fires on every edge its edge qualifier selects
// - continuous capture overwrites both values and difference
// - signed difference, sign set by event order
// - one-shot sampling stores counts after sampling time
// - continuous sampling repeats store per trigger change
// - sampling capture needs no enable; one-shot re-armed by control write
// - sampling start: control 0 high/low or enable
// - one-shot sampling sets only capture 1 status
// - continuous sampling sets only capture 0 status
// - values are signed 32-bit, latest capture kept
// - status becomes visible only at refresh points
// - plain capture status cleared on enable rise
// - captures run freely; completion flags cleared at refresh
// - frequent triggers just keep status set
// - overflow/underflow stops unless continue is configured
// - plain capture armed only while enable held
// - one-shot plain capture takes first edge only
// - sampling selection disables plain capture
module ccu_capture
    import ccu_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [CCU_AW-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic signed [31:0] count_in,
    input wire logic overflow_in,
    input wire logic underflow_in,
    input wire logic ctrl0_in,
    input wire logic ctrl1_in,
    input wire logic io_refresh_in,
    output logic [1:0] cap_status_out,
    output logic err_out,
    output logic run_out
);

    // true when the channel's source and edge qualifier see an edge
    function automatic logic trig_hit(input logic src, input logic [1:0] edg,
                                      input logic [1:0] rise, input logic [1:0] fall);
        logic r;
        logic f;
        r = src ? rise[1] : rise[0];
        f = src ? fall[1] : fall[0];
        trig_hit = (edg[0] & r) | (edg[1] & f);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    ccu_ctrl_t ctrl_r, ctrl_nxt;
    logic [CCU_STIME_W-1:0] stime_r, stime_nxt;
    logic signed [31:0] cap0_r, cap0_nxt;
    logic signed [31:0] cap1_r, cap1_nxt;
    logic signed [31:0] diff_r, diff_nxt;
    logic signed [31:0] sref_r, sref_nxt;
    logic [1:0] done_r, done_nxt;
    logic [1:0] taken_r, taken_nxt;
    logic [1:0] status_r, status_nxt;
    logic sdone_r, sdone_nxt;
    logic err_r, err_nxt;
    logic run_r, run_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;
    logic samp_act;
    logic en_rise;
    logic plain_arm;
    logic fire0;
    logic fire1;
    logic samp_start;
    logic samp_exp;
    logic [1:0] set_now;
    logic ctrl_wr;

    ////////////////////////////////////////////////////////////////////////////
    // edges and sampling timer

    // start condition of sampling capture from its selected source
    always_comb begin
        unique case (ctrl_r.samp_src)
            CCU_SS_C0_HIGH: samp_act = ctrl0_in;
            CCU_SS_C0_LOW: samp_act = ~ctrl0_in;
            CCU_SS_ENREQ: samp_act = ctrl_r.en_req;
            default: samp_act = 1'b0;
        endcase
    end

    // every level whose edges matter goes through one shared history register
    assign lvl = {samp_act, ctrl_r.en_req, ctrl1_in, ctrl0_in};

    ccu_edge #(.W(4)) u_edge (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .level_in(lvl),
        .rise_out(rise),
        .fall_out(fall)
    );

    // enable edge and control write strobe, used by several groups below
    assign en_rise = rise[2];
    assign ctrl_wr = wr_in && (addr_in == CCU_OFS_CTRL);

    // sampling runs without the enable bit; one-shot waits for re-arm
    assign samp_start = ctrl_r.samp_sel && run_r && rise[3]
                        && (ctrl_r.cont || !sdone_r);

    ccu_timer u_timer (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .load_in(samp_start),
        .abort_in(!ctrl_r.samp_sel || !run_r),
        .value_in(stime_r),
        .expire_out(samp_exp)
    );

    // plain capture only while enable held and sampling not selected
    assign plain_arm = ctrl_r.en_req && !ctrl_r.samp_sel && run_r;
    assign fire0 = plain_arm && (ctrl_r.cont || !taken_r[0])
                   && trig_hit(ctrl_r.c0_src, ctrl_r.c0_edge, rise[1:0], fall[1:0]);
    assign fire1 = plain_arm && (ctrl_r.cont || !taken_r[1])
                   && trig_hit(ctrl_r.c1_src, ctrl_r.c1_edge, rise[1:0], fall[1:0]);

    ////////////////////////////////////////////////////////////////////////////
    // capture values and completion flags

    always_comb begin
        cap0_nxt = cap0_r;
        cap1_nxt = cap1_r;
        diff_nxt = diff_r;
        sref_nxt = sref_r;
        taken_nxt = taken_r;
        sdone_nxt = sdone_r;
        set_now = 2'b00;
        // rewriting control re-arms a finished one-shot sampling; an expiry
        // in the same cycle still marks it done, so the set wins
        if (ctrl_wr) begin
            sdone_nxt = 1'b0;
        end
        if (samp_start) begin
            sref_nxt = count_in;
        end
        if (samp_exp) begin
            cap0_nxt = count_in;
            cap1_nxt = count_in;
            diff_nxt = count_in - sref_r;
            if (ctrl_r.cont) begin
                set_now[0] = 1'b1;
            end else begin
                set_now[1] = 1'b1;
                sdone_nxt = 1'b1;
            end
        end
        // a new enable starts a fresh one-shot round
        if (en_rise) begin
            taken_nxt = 2'b00;
        end
        if (fire0) begin
            cap0_nxt = count_in;
            taken_nxt[0] = 1'b1;
            set_now[0] = 1'b1;
        end
        if (fire1) begin
            cap1_nxt = count_in;
            taken_nxt[1] = 1'b1;
            set_now[1] = 1'b1;
        end
        // difference follows which capture came first
        if (fire0 || fire1) begin
            diff_nxt = cap1_nxt - cap0_nxt;
        end
    end

    // capture registers; values survive an error stop for later reading
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cap0_r <= '0;
            cap1_r <= '0;
            diff_r <= '0;
            sref_r <= '0;
            taken_r <= 2'b00;
            sdone_r <= 1'b0;
        end else begin
            cap0_r <= cap0_nxt;
            cap1_r <= cap1_nxt;
            diff_r <= diff_nxt;
            sref_r <= sref_nxt;
            taken_r <= taken_nxt;
            sdone_r <= sdone_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // internal completion flags and published status

    // an event in a refresh cycle is published, never dropped
    always_comb begin
        done_nxt = done_r | set_now;
        status_nxt = status_r;
        if (io_refresh_in) begin
            status_nxt = done_r | set_now;
            done_nxt = 2'b00;
        end else if (en_rise && !ctrl_r.samp_sel) begin
            status_nxt = 2'b00;
            done_nxt = set_now;
        end
    end

    // completion flags and the published status bits
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_r <= 2'b00;
            status_r <= 2'b00;
        end else begin
            done_r <= done_nxt;
            status_r <= status_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter error and run state

    // stop is the default; continue-on-error keeps the block running
    always_comb begin
        err_nxt = err_r;
        run_nxt = run_r;
        if (wr_in && addr_in == CCU_OFS_STATUS && wdata_in[CCU_STATUS_ERR_BIT]) begin
            err_nxt = 1'b0;
            run_nxt = 1'b1;
        end
        if (overflow_in || underflow_in) begin
            err_nxt = 1'b1;
            run_nxt = ctrl_r.cont_err && run_r;
        end
    end

    // the block comes out of reset running and free of errors
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            err_r <= 1'b0;
            run_r <= 1'b1;
        end else begin
            err_r <= err_nxt;
            run_r <= run_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port: writes take effect next edge, reads answer next cycle

    always_comb begin
        ctrl_nxt = ctrl_r;
        stime_nxt = stime_r;
        rdata_nxt = 32'h0000_0000;
        if (ctrl_wr) begin
            ctrl_nxt = ccu_ctrl_t'(wdata_in[CCU_CTRL_W-1:0]);
        end
        if (wr_in && addr_in == CCU_OFS_STIME) begin
            stime_nxt = wdata_in[CCU_STIME_W-1:0];
        end
        if (rd_in) begin
            unique case (addr_in)
                CCU_OFS_CTRL: rdata_nxt = {20'h00000, ctrl_r};
                CCU_OFS_STIME: rdata_nxt = {16'h0000, stime_r};
                CCU_OFS_STATUS: rdata_nxt = {28'h0000000, run_r, err_r, status_r};
                CCU_OFS_CAP0: rdata_nxt = cap0_r;
                CCU_OFS_CAP1: rdata_nxt = cap1_r;
                CCU_OFS_DIFF: rdata_nxt = diff_r;
                CCU_OFS_COUNT: rdata_nxt = count_in;
                default: rdata_nxt = 32'h0000_0000;  // unmapped reads zero
            endcase
        end
    end

    // control, sampling time and the registered read answer
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_r <= ccu_ctrl_t'(CCU_CTRL_RST);
            stime_r <= CCU_STIME_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            stime_r <= stime_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // every output is a flip-flop, so nothing combinational reaches the pins
    assign rdata_out = rdata_r;
    assign cap_status_out = status_r;
    assign err_out = err_r;
    assign run_out = run_r;

endmodule // ccu_capture

// ---- ccu_capture_monitor.sv ----
`timescale 1ns/1ps

// port-level checks; a shadow of the control word stands in for mode bits
module ccu_capture_mon
    import ccu_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [CCU_AW-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic signed [31:0] count_in,
    input wire logic overflow_in,
    input wire logic underflow_in,
    input wire logic ctrl0_in,
    input wire logic ctrl1_in,
    input wire logic io_refresh_in,
    input wire logic [1:0] cap_status_out,
    input wire logic err_out,
    input wire logic run_out
);
    logic [11:0] ctrl_r;
    logic [11:0] ctrl_nxt;
    logic clr_req;
    logic ev_err;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // error events and the write that clears them
    assign clr_req = wr_in && addr_in == CCU_OFS_STATUS && wdata_in[CCU_STATUS_ERR_BIT];
    assign ev_err = overflow_in || underflow_in;

    // shadow moves on the same edge as the real register, so no lag to allow for
    always_comb begin
        ctrl_nxt = (wr_in && addr_in == CCU_OFS_CTRL) ? wdata_in[11:0] : ctrl_r;
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_r <= CCU_CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////
    property p_status_hold;
        !$past(io_refresh_in) && !$past(wr_in) && !$past(wr_in, 2) |-> $stable(cap_status_out);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status moved off refresh");
    property p_flag_clear;
        io_refresh_in && $past(io_refresh_in) && !$past(wr_in) && !ctrl_r[2]
            && $stable(ctrl0_in) && $stable(ctrl1_in) |=> cap_status_out == 2'h0;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("done flag kept");
    property p_en_clear;
        wr_in && addr_in == CCU_OFS_CTRL && wdata_in[0] && !wdata_in[2] && !ctrl_r[0]
            && !io_refresh_in ##1 !io_refresh_in |-> ##[0:1] cap_status_out == 2'h0;
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("status not cleared");
    property p_err_set;
        ev_err |=> err_out;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error not raised");
    property p_err_hold;
        err_out && !clr_req |=> err_out;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error dropped");
    property p_run_stop;
        ev_err && !ctrl_r[3] |=> !run_out;
    endproperty
    a_run_stop: assert property (p_run_stop) else $error("run kept on error");
    property p_run_keep;
        ev_err && ctrl_r[3] && run_out |=> run_out;
    endproperty
    a_run_keep: assert property (p_run_keep) else $error("run stopped");
    property p_run_back;
        $rose(run_out) |-> $past(clr_req);
    endproperty
    a_run_back: assert property (p_run_back) else $error("run resumed alone");
    property p_count_rd;
        rd_in && addr_in == CCU_OFS_COUNT |=> rdata_out == $past(count_in);
    endproperty
    a_count_rd: assert property (p_count_rd) else $error("count readback");
endmodule // ccu_capture_mon

bind ccu_capture ccu_capture_mon u_mon (
    .clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .count_in,
    .overflow_in, .underflow_in, .ctrl0_in, .ctrl1_in, .io_refresh_in, .cap_status_out,
    .err_out, .run_out
);

// ---- ccu_far_model.sv ----
`timescale 1ns/1ps

// counting stage on the far side; a load parks it near either end of the range
module ccu_far_model (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic load_in,
    input wire logic signed [31:0] load_val_in,
    input wire logic down_in,
    output logic signed [31:0] count_out,
    output logic overflow_out,
    output logic underflow_out
);
    logic signed [31:0] count_r;
    logic signed [31:0] count_nxt;

    // wrap flags are high for the one cycle in which the count passes an end
    assign overflow_out = !down_in && count_r == 32'h7FFF_FFFF;
    assign underflow_out = down_in && count_r == 32'h8000_0000;
    assign count_out = count_r;

    // one step a clock, so every captured value is predictable
    always_comb begin
        count_nxt = load_in ? load_val_in : (down_in ? count_r - 1 : count_r + 1);
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_r <= 32'h0;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule // ccu_far_model

// ---- tb_top.sv ----
`timescale 1ns/1ps

`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end

module tb_top
    import ccu_pkg::*;
();
    logic clk_in, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, io_refresh_in = 1'b0;
    logic ctrl0_in = 1'b0, ctrl1_in = 1'b0, ld = 1'b0, dn = 1'b0, ovf, unf, err_out, run_out;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out, b;
    logic signed [31:0] cnt, c0, c1, st, x, ld_val = 32'h0;
    logic [1:0] cap_status_out;
    int fail_count = 0, tests_run = 0, cycles = 0;

    ccu_capture dut (
        .clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .count_in(cnt), .overflow_in(ovf), .underflow_in(unf), .ctrl0_in, .ctrl1_in,
        .io_refresh_in, .cap_status_out, .err_out, .run_out
    );
    ccu_far_model u_far (
        .clk_in, .resetn_in, .load_in(ld), .load_val_in(ld_val), .down_in(dn),
        .count_out(cnt), .overflow_out(ovf), .underflow_out(unf)
    );

    // clock and a hang guard well above the few hundred cycles needed
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            complete_run;
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // live count is compared against the count of the strobe cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        #1 e = (a == CCU_OFS_COUNT) ? cnt : e;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 `CHK("rdata", e, rdata_out)
    endtask
    task automatic refresh(input int n);
        @(posedge clk_in);
        io_refresh_in <= 1'b1;
        repeat (n) @(posedge clk_in);
        io_refresh_in <= 1'b0;
        #1;
    endtask
    task automatic ctl(input bit w, input logic v, output logic signed [31:0] c);
        @(posedge clk_in);
        if (w) ctrl1_in <= v;
        else ctrl0_in <= v;
        #1 c = cnt;
    endtask
    task automatic load(input logic d, input logic [31:0] v);
        @(posedge clk_in);
        dn <= d;
        ld <= 1'b1;
        ld_val <= v;
        @(posedge clk_in);
        ld <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(CCU_OFS_CTRL, 32'h0);
        rd(CCU_OFS_STIME, 32'h1);
        rd(CCU_OFS_STATUS, 32'h8);
        rd(8'hFC, 32'h0);
        rd(CCU_OFS_COUNT, 32'h0);
    endtask
    // one-shot, both event orders, disabled and blocked triggers
    task automatic t_plain;
        wr(CCU_OFS_CTRL, 32'h681);
        ctl(0, 1, c0);
        tick(1);
        ctl(1, 1, c1);
        ctl(0, 0, x);
        ctl(0, 1, x);
        tick(1);
        `CHK("status", 2'h0, cap_status_out)
        rd(CCU_OFS_CAP0, c0);
        rd(CCU_OFS_CAP1, c1);
        rd(CCU_OFS_DIFF, 32'h2);
        refresh(1);
        `CHK("status", 2'h3, cap_status_out)
        wr(CCU_OFS_CTRL, 32'h680);
        ctl(0, 0, x);
        ctl(0, 1, x);
        rd(CCU_OFS_CAP0, c0);
        ctl(0, 0, x);
        ctl(1, 0, x);
        wr(CCU_OFS_CTRL, 32'h681);
        tick(1);
        `CHK("status", 2'h0, cap_status_out)
        refresh(2);
        `CHK("status", 2'h0, cap_status_out)
        ctl(1, 1, c1);
        tick(1);
        ctl(0, 1, c0);
        rd(CCU_OFS_DIFF, 32'hFFFF_FFFE);
    endtask
    task automatic t_cont;
        wr(CCU_OFS_CTRL, 32'h783);
        for (int i = 0; i < 3; i++) begin
            ctl(0, i[0], c0);
            refresh(1);
            `CHK("status0", 1'b1, cap_status_out[0])
            rd(CCU_OFS_CAP0, c0);
        end
        ctl(0, 1, x);
        ctl(0, 0, c0);
        refresh(1);
        `CHK("status0", 1'b1, cap_status_out[0])
        rd(CCU_OFS_CAP0, c0);
        ctl(1, 0, x);
        ctl(1, 1, c1);
        rd(CCU_OFS_CAP1, c1);
        rd(CCU_OFS_DIFF, c1 - c0);
        refresh(1);
        `CHK("status", 2'h2, cap_status_out)
    endtask
    // every start source in one-shot and continuous form, enable set only for the enable source
    task automatic t_samp;
        wr(CCU_OFS_STIME, 32'h3);
        for (int s = 0; s < 3; s++) begin
            for (int c = 0; c < 2; c++) begin
                b = 32'h4 | (s << 4) | (c << 1);
                ctl(0, s == 1, x);
                wr(CCU_OFS_CTRL, b);
                refresh(1);
                if (s == 2) begin
                    wr(CCU_OFS_CTRL, b | 32'h1);
                    #1 st = cnt;
                end else begin
                    ctl(0, s != 1, st);
                end
                tick(5);
                rd(CCU_OFS_DIFF, 32'h3);
                rd(CCU_OFS_CAP0, st + 3);
                refresh(1);
                `CHK("status", c ? 2'h1 : 2'h2, cap_status_out)
                if (s < 2) begin
                    ctl(0, s == 1, x);
                    ctl(0, s != 1, x);
                    tick(5);
                    rd(CCU_OFS_CAP1, c ? x + 3 : st + 3);
                end
            end
        end
        // plain trigger with enable held while sampling is selected
        wr(CCU_OFS_CTRL, 32'hA7);
        ctl(0, 1, x);
        tick(1);
        rd(CCU_OFS_CAP0, st + 3);
    endtask
    // wrap at both ends, stop and clear, then continue-on-error
    task automatic t_err;
        wr(CCU_OFS_CTRL, 32'h83);
        ctl(0, 0, x);
        load(1'b0, 32'h7FFF_FFFD);
        ctl(0, 1, x);
        tick(4);
        `CHK("err", 1'b1, err_out)
        `CHK("run", 1'b0, run_out)
        ctl(0, 0, x);
        ctl(0, 1, x);
        rd(CCU_OFS_CAP0, 32'h7FFF_FFFE);
        wr(CCU_OFS_STATUS, 32'h4);
        tick(1);
        `CHK("run", 1'b1, run_out)
        wr(CCU_OFS_CTRL, 32'h8B);
        ctl(0, 0, x);
        load(1'b1, 32'h8000_0002);
        ctl(0, 1, x);
        tick(4);
        `CHK("err", 1'b1, err_out)
        `CHK("run", 1'b1, run_out)
        rd(CCU_OFS_CAP0, 32'h8000_0001);
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_reset;
        t_plain;
        t_cont;
        t_samp;
        t_err;
        complete_run;
    end
endmodule // tb_top
